// [src/week_timer_map.vh]
`ifndef WEEK_TIMER_MAP_VH
`define WEEK_TIMER_MAP_VH

// counter and select widths
`define WT_WEEK_W        28
`define WT_SUB_W         9
`define WT_DIV_W         15
`define WT_SEL_W         4
`define WT_TICK_W        3

// divider wraps to zero after this value
`define WT_DIV_LAST      15'h7FFF
`define WT_DIV_RESET     15'h0000

// reset values
`define WT_WEEK_RESET    28'h000_0000
`define WT_CMP_RESET     28'hFFF_FFFF
`define WT_SUB_RESET     9'h000

// sub-week tick source codes
`define WT_TICK_OFF      3'h0
`define WT_TICK_SUBSEC   3'h1
`define WT_TICK_SECOND   3'h2
`define WT_TICK_RSVD     3'h3
`define WT_TICK_WEEK3    3'h4
`define WT_TICK_WEEK5    3'h5
`define WT_TICK_WEEK7    3'h6
`define WT_TICK_WEEK9    3'h7

// fraction rate code that turns the fractional tick off
`define WT_SEL_OFF       4'h0

`endif

// [src/battery_week_alarm_timer.v]
`timescale 1ns/10ps
`include "week_timer_map.vh"

module battery_week_alarm_timer #(
	parameter WEEK_W = `WT_WEEK_W,
	parameter SUB_W  = `WT_SUB_W,
	parameter DIV_W  = `WT_DIV_W
) (
	input  wire              sys_clk_i,
	input  wire              rst_i,
	input  wire              ce_i,
	input  wire              block_enable_i,
	input  wire              standby_rail_reset_n_i,
	input  wire              ec_host_i,
	input  wire              week_cnt_wr_i,
	input  wire [WEEK_W-1:0] week_cnt_data_i,
	input  wire              week_cmp_wr_i,
	input  wire [WEEK_W-1:0] week_cmp_data_i,
	input  wire              sub_cnt_wr_i,
	input  wire [SUB_W-1:0]  sub_cnt_data_i,
	input  wire [2:0]        sub_tick_sel_i,
	input  wire              sub_repeat_i,
	input  wire [3:0]        fraction_rate_select_i,
	input  wire              wake_output_enable_i,
	input  wire              supply_gate_enable_i,
	input  wire              supply_present_pin_i,
	output wire              week_alarm_irq_o,
	output wire              sub_week_alarm_irq_o,
	output wire              one_second_irq_o,
	output wire              sub_second_irq_o,
	output wire              system_supply_present_wake_o,
	output wire              wake_event_o,
	output wire [WEEK_W-1:0] week_cnt_o,
	output wire [SUB_W-1:0]  sub_cnt_o
);

	// state registers
	// every flop here sits on the battery rail; the standby reset clears
	// none of them, so time keeps running across standby outages
	// only rst_i, the battery power-on reset, returns them to reset values
	reg [DIV_W-1:0]  div_ff;
	reg [WEEK_W-1:0] week_ff;
	reg [WEEK_W-1:0] cmp_ff;
	reg [SUB_W-1:0]  sub_ff;
	reg [SUB_W-1:0]  sub_reload_ff;
	reg              match_ff;
	reg              week_irq_ff;
	reg              sub_irq_ff;
	reg              sec_irq_ff;
	reg              frac_irq_ff;
	reg              pres_wake_ff;
	reg              wake_ff;
	reg              stby_meta_ff;
	reg              stby_ff;
	reg              pres_meta_ff;
	reg              pres_ff;

	// next values
	reg [DIV_W-1:0]  nxt_div;
	reg [WEEK_W-1:0] nxt_week;
	reg [WEEK_W-1:0] nxt_cmp;
	reg [SUB_W-1:0]  nxt_sub;
	reg [SUB_W-1:0]  nxt_sub_reload;
	reg              nxt_match;
	reg              nxt_week_irq;
	reg              nxt_sub_irq;
	reg              nxt_sec_irq;
	reg              nxt_frac_irq;
	reg              nxt_pres_wake;
	reg              nxt_wake;

	// decoded events of the current cycle
	wire             run;
	wire             wr_ok;
	wire             sec_tick;
	wire             frac_tick;
	reg              sub_tick;
	wire             match_now;
	reg              week_evt;
	reg              sub_evt;
	wire             wake_inhibit;

	// low bits all ones: next increment carries past this width
	// a week-bit tick source fires when the second tick carries into bit k,
	// which is exactly when bits k-1 down to 0 are all ones
	// limitation: rewriting the week counter while such a source is chosen
	// can add or drop a sub-week tick, so stop the countdown first
	function all_ones_low;
		input [WEEK_W-1:0] val;
		input [4:0]        width;
		reg   [WEEK_W-1:0] mask;
		begin
			mask = ~({WEEK_W{1'b1}} << width);
			all_ones_low = ((val & mask) == mask);
		end
	endfunction

	// code n ticks at 2^n Hz: low (15-n) divider bits all ones
	// code 15 leaves an empty mask, so it hits on every clock
	// trade-off: this mapping stops at 2 Hz; a 0.5 Hz rate is not reachable
	// pulses line up with the divider, so they stay evenly spaced
	function frac_hit;
		input [DIV_W-1:0] div;
		input [3:0]       sel;
		reg   [DIV_W-1:0] mask;
		begin
			mask = `WT_DIV_LAST >> sel;
			frac_hit = (sel != `WT_SEL_OFF) && ((div & mask) == mask);
		end
	endfunction

	// pin-side levels cross two flip-flops before use
	// only the second flop of each pair is read by any logic
	// the pairs clear to zero, so writes stay refused for two edges after
	// power-on reset; cheaper than a separate reset value per rail
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			stby_meta_ff <= 1'b0;
			stby_ff      <= 1'b0;
			pres_meta_ff <= 1'b0;
			pres_ff      <= 1'b0;
		end else if (ce_i) begin
			stby_meta_ff <= standby_rail_reset_n_i;
			stby_ff      <= stby_meta_ff;
			pres_meta_ff <= supply_present_pin_i;
			pres_ff      <= pres_meta_ff;
		end
	end

	// no sleep input exists; only the enable and ce_i stop counting
	// the host select comes from logic on this clock, so it needs no sync
	assign run   = block_enable_i;
	// standby reset gates writes only, counting goes on
	assign wr_ok = stby_ff & ec_host_i;

	// one-hertz tick on the divider wrap
	assign sec_tick  = run && (div_ff == `WT_DIV_LAST);
	assign frac_tick = run && frac_hit(div_ff, fraction_rate_select_i);
	assign match_now = (week_ff >= cmp_ff);

	// an open supply-present gate stops a wake that would drain the battery
	// an inhibited wake is not remembered: the alarm pulse still goes out,
	// but the wake latch stays clear until the next alarm event
	assign wake_inhibit = !wake_output_enable_i ||
		(supply_gate_enable_i && !pres_ff);

	// sub-week tick source mux
	// codes 0 and 3 select no source, which parks the countdown
	// every source is gated by run, so a disabled block never ticks
	always @* begin
		case (sub_tick_sel_i)
		`WT_TICK_SUBSEC: sub_tick = frac_tick;
		`WT_TICK_SECOND: sub_tick = sec_tick;
		`WT_TICK_WEEK3:  sub_tick = sec_tick && all_ones_low(week_ff, 5'd3);
		`WT_TICK_WEEK5:  sub_tick = sec_tick && all_ones_low(week_ff, 5'd5);
		`WT_TICK_WEEK7:  sub_tick = sec_tick && all_ones_low(week_ff, 5'd7);
		`WT_TICK_WEEK9:  sub_tick = sec_tick && all_ones_low(week_ff, 5'd9);
		default:         sub_tick = 1'b0;
		endcase
	end

	// counters, compare and alarm detection
	// the divider free-runs while enabled and wraps on its own width
	// the week alarm is the entry into the at-or-above level, so a compare
	// rewritten below the count fires once more; that is intended
	// a zero sub count never steps, so an idle countdown cannot underflow
	always @* begin
		nxt_div        = div_ff;
		nxt_week       = week_ff;
		nxt_cmp        = cmp_ff;
		nxt_sub        = sub_ff;
		nxt_sub_reload = sub_reload_ff;
		nxt_match      = match_ff;
		week_evt       = 1'b0;
		sub_evt        = 1'b0;
		if (run) begin
			nxt_div = div_ff + {{(DIV_W-1){1'b0}}, 1'b1};
			if (sec_tick) begin
				nxt_week = week_ff + {{(WEEK_W-1){1'b0}}, 1'b1};
			end
			// only the entry into match counts, so one pulse per crossing
			nxt_match = match_now;
			week_evt  = match_now && !match_ff;
			if (sub_tick && (sub_ff != {SUB_W{1'b0}})) begin
				nxt_sub = sub_ff - {{(SUB_W-1){1'b0}}, 1'b1};
				if (sub_ff == {{(SUB_W-1){1'b0}}, 1'b1}) begin
					sub_evt = 1'b1;
					if (sub_repeat_i) begin
						nxt_sub = sub_reload_ff;
					end
				end
			end
		end
		// firmware writes take precedence over counting
		// hazard: a week count write in the cycle of a second tick drops that increment
		if (wr_ok && week_cnt_wr_i) begin
			nxt_week = week_cnt_data_i;
		end
		if (wr_ok && week_cmp_wr_i) begin
			nxt_cmp = week_cmp_data_i;
		end
		// writing zero stops the countdown
		if (wr_ok && sub_cnt_wr_i) begin
			nxt_sub        = sub_cnt_data_i;
			nxt_sub_reload = sub_cnt_data_i;
		end
	end

	// interrupt pulses and wake latch
	// each pulse is the event of the cycle before, one clock per event, so
	// events on consecutive cycles, like the code 15 fractional tick, merge into one long level
	// masking is left to the aggregator; nothing here can hold a pulse off
	always @* begin
		nxt_week_irq  = week_evt;
		nxt_sub_irq   = sub_evt;
		nxt_sec_irq   = sec_tick;
		nxt_frac_irq  = frac_tick;
		nxt_pres_wake = week_evt || sub_evt;
		nxt_wake      = wake_ff;
		// the set wins, and it cannot occur while the enable is low
		if ((week_evt || sub_evt) && !wake_inhibit) begin
			nxt_wake = 1'b1;
		end else if (!wake_output_enable_i) begin
			nxt_wake = 1'b0;
		end
	end

	// battery-rail state; ce low freezes everything
	// reset is synchronous and overrides ce, unlike every other update
	// the compare resets to all ones so no alarm follows power-on
	always @(posedge sys_clk_i) begin
		if (rst_i) begin
			div_ff        <= `WT_DIV_RESET;
			week_ff       <= `WT_WEEK_RESET;
			cmp_ff        <= `WT_CMP_RESET;
			sub_ff        <= `WT_SUB_RESET;
			sub_reload_ff <= `WT_SUB_RESET;
			match_ff      <= 1'b0;
			week_irq_ff   <= 1'b0;
			sub_irq_ff    <= 1'b0;
			sec_irq_ff    <= 1'b0;
			frac_irq_ff   <= 1'b0;
			pres_wake_ff  <= 1'b0;
			wake_ff       <= 1'b0;
		end else if (ce_i) begin
			div_ff        <= nxt_div;
			week_ff       <= nxt_week;
			cmp_ff        <= nxt_cmp;
			sub_ff        <= nxt_sub;
			sub_reload_ff <= nxt_sub_reload;
			match_ff      <= nxt_match;
			week_irq_ff   <= nxt_week_irq;
			sub_irq_ff    <= nxt_sub_irq;
			sec_irq_ff    <= nxt_sec_irq;
			frac_irq_ff   <= nxt_frac_irq;
			pres_wake_ff  <= nxt_pres_wake;
			wake_ff       <= nxt_wake;
		end
	end

	// outputs straight from flip-flops
	// no logic sits between the flops and the pins, so the aggregator and
	// the battery control interface see glitch-free levels
	assign week_alarm_irq_o             = week_irq_ff;
	assign sub_week_alarm_irq_o         = sub_irq_ff;
	assign one_second_irq_o             = sec_irq_ff;
	assign sub_second_irq_o             = frac_irq_ff;
	assign system_supply_present_wake_o = pres_wake_ff;
	assign wake_event_o                 = wake_ff;
	assign week_cnt_o                   = week_ff;
	assign sub_cnt_o                    = sub_ff;

endmodule // battery_week_alarm_timer

// [verification/week_timer_chk.sv]
`timescale 1ns/10ps
module week_timer_chk #(
	parameter SUB_W = 9
) (
	input wire             sys_clk_i,
	input wire             rst_i,
	input wire             block_enable_i,
	input wire [3:0]       fraction_rate_select_i,
	input wire             wake_output_enable_i,
	input wire             supply_gate_enable_i,
	input wire             sub_cnt_wr_i,
	input wire [SUB_W-1:0] sub_cnt_o,
	input wire             week_alarm_irq_o,
	input wire             sub_week_alarm_irq_o,
	input wire             one_second_irq_o,
	input wire             sub_second_irq_o,
	input wire             system_supply_present_wake_o,
	input wire             wake_event_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// $past(rst_i) guards keep a short mid-run reset from faking a step
	a_alarm_wake_pulse: assert property (
		(week_alarm_irq_o || sub_week_alarm_irq_o)
		|-> system_supply_present_wake_o) else $error("alarm lacks wake pulse");
	a_sub_step_alarm: assert property (
		$past(sub_cnt_o) == 9'h001 && sub_cnt_o == 9'h000 && !$past(rst_i)
		&& !$past(sub_cnt_wr_i) |-> sub_week_alarm_irq_o)
		else $error("countdown end without alarm");
	a_one_sec_pulse: assert property (
		one_second_irq_o |=> !one_second_irq_o [*8])
		else $error("second tick too wide or too close");
	a_week_irq_single: assert property (
		week_alarm_irq_o |=> !week_alarm_irq_o) else $error("week alarm wide");
	a_wake_release: assert property (
		!wake_output_enable_i |=> !wake_event_o) else $error("wake not released");
	a_wake_on_alarm: assert property (
		system_supply_present_wake_o && $past(wake_output_enable_i)
		&& !$past(supply_gate_enable_i) |-> wake_event_o)
		else $error("alarm did not raise wake");
	a_disabled_quiet: assert property (
		!block_enable_i && !$past(block_enable_i)
		|-> !one_second_irq_o && !sub_second_irq_o)
		else $error("tick while disabled");
	a_frac_full_rate: assert property (
		$past(block_enable_i) && $past(fraction_rate_select_i) == 4'hF
		&& !$past(rst_i) |-> sub_second_irq_o)
		else $error("full rate tick missing");
endmodule // week_timer_chk

bind battery_week_alarm_timer week_timer_chk #(.SUB_W(SUB_W)) u_week_timer_chk (
	.sys_clk_i, .rst_i, .block_enable_i, .fraction_rate_select_i,
	.wake_output_enable_i, .supply_gate_enable_i, .sub_cnt_wr_i, .sub_cnt_o,
	.week_alarm_irq_o, .sub_week_alarm_irq_o, .one_second_irq_o,
	.sub_second_irq_o, .system_supply_present_wake_o, .wake_event_o);

// [verification/battery_control_model.sv]
`timescale 1ns/10ps
module battery_control_model (
	input  wire wake_event_i,
	output wire ext_wake_o
);
	// follows the wake event straight onto the external pin, no latch
	assign ext_wake_o = wake_event_i;
endmodule // battery_control_model

// [verification/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic        sys_clk_i = 1'b0;
	logic        rst_i, block_enable_i, standby_rail_reset_n_i, ec_host_i;
	logic        week_cnt_wr_i, week_cmp_wr_i, sub_cnt_wr_i;
	logic [27:0] week_cnt_data_i, week_cmp_data_i;
	logic [8:0]  sub_cnt_data_i;
	logic [2:0]  sub_tick_sel_i;
	logic        sub_repeat_i;
	logic [3:0]  fraction_rate_select_i;
	logic        wake_output_enable_i, supply_gate_enable_i, supply_present_pin_i;
	wire  [27:0] week_cnt_o;
	wire  [8:0]  sub_cnt_o;
	wire         week_alarm_irq_o, sub_week_alarm_irq_o, one_second_irq_o;
	wire         sub_second_irq_o, system_supply_present_wake_o, wake_event_o;
	wire         ext_wake;
	int          failures = 0;
	int          num_checks = 0;
	int          n;

	always #25 sys_clk_i = ~sys_clk_i;

	battery_week_alarm_timer u_battery_week_alarm_timer (.sys_clk_i, .rst_i,
		.ce_i(1'b1), .block_enable_i, .standby_rail_reset_n_i, .ec_host_i,
		.week_cnt_wr_i, .week_cnt_data_i, .week_cmp_wr_i, .week_cmp_data_i,
		.sub_cnt_wr_i, .sub_cnt_data_i, .sub_tick_sel_i, .sub_repeat_i,
		.fraction_rate_select_i, .wake_output_enable_i, .supply_gate_enable_i,
		.supply_present_pin_i, .week_alarm_irq_o, .sub_week_alarm_irq_o,
		.one_second_irq_o, .sub_second_irq_o, .system_supply_present_wake_o,
		.wake_event_o, .week_cnt_o, .sub_cnt_o);
	battery_control_model u_battery_control_model (.wake_event_i(wake_event_o),
		.ext_wake_o(ext_wake));

	// shared compare, four-state exact
	task automatic chk(input logic [27:0] got, input logic [27:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask

	// k selects 0 week count, 1 compare, 2 sub count; strobe held one cycle
	task automatic wr(input int k, input logic [27:0] d);
		@(negedge sys_clk_i);
		week_cnt_wr_i = (k == 0);
		week_cmp_wr_i = (k == 1);
		sub_cnt_wr_i = (k == 2);
		week_cnt_data_i = d;
		week_cmp_data_i = d;
		sub_cnt_data_i = d[8:0];
		@(negedge sys_clk_i);
		{week_cnt_wr_i, week_cmp_wr_i, sub_cnt_wr_i} = 3'b000;
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// two one-second periods plus setup stay well under this span
	initial begin
		#(90000 * 50);
		failures++;
		finish_test();
	end

	initial begin
		{rst_i, standby_rail_reset_n_i, ec_host_i} = 3'b111;
		{block_enable_i, week_cnt_wr_i, week_cmp_wr_i, sub_cnt_wr_i} = 4'h0;
		{week_cnt_data_i, week_cmp_data_i, sub_cnt_data_i} = '0;
		{sub_tick_sel_i, fraction_rate_select_i} = '0;
		sub_repeat_i = 1'b0;
		{wake_output_enable_i, supply_gate_enable_i, supply_present_pin_i} = '0;
		cyc(5);
		rst_i = 1'b0;
		chk(week_cnt_o, 28'h000_0000);
		chk(wake_event_o, 28'h000_0000);
		cyc(3);
		ec_host_i = 1'b0;
		wr(0, 28'h000_0005);
		chk(week_cnt_o, 28'h000_0000);
		ec_host_i = 1'b1;
		wr(0, 28'h000_0005);
		chk(week_cnt_o, 28'h000_0005);
		standby_rail_reset_n_i = 1'b0;
		cyc(3);
		wr(0, 28'h000_0009);
		chk(week_cnt_o, 28'h000_0005);
		standby_rail_reset_n_i = 1'b1;
		cyc(3);
		// count fractional ticks in a 256-cycle window; code 0 must stay quiet
		block_enable_i = 1'b1;
		for (int s = 6; s < 16; s++) begin
			fraction_rate_select_i = (s == 6) ? 4'h0 : 4'(s);
			n = 0;
			cyc(2);
			repeat (256) begin
				@(negedge sys_clk_i);
				if (sub_second_irq_o === 1'b1)
					n++;
			end
			chk(n, (s == 6) ? 0 : 256 >> (15 - s));
		end
		// compare below the count must still fire, exactly once
		wake_output_enable_i = 1'b1;
		wr(1, 28'h000_0003);
		n = 0;
		repeat (4) begin
			@(negedge sys_clk_i);
			if (week_alarm_irq_o === 1'b1)
				n++;
		end
		chk(n, 1);
		chk(wake_event_o, 1);
		chk(ext_wake, 1);
		wake_output_enable_i = 1'b0;
		cyc(2);
		chk(wake_event_o, 0);
		// one-shot countdown on the second tick, wake gated by missing supply
		{wake_output_enable_i, supply_gate_enable_i} = 2'b11;
		wr(2, 28'h000_0001);
		sub_tick_sel_i = 3'h2;
		n = 0;
		while (one_second_irq_o !== 1'b1 && n < 40000) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk(sub_week_alarm_irq_o, 1);
		chk(system_supply_present_wake_o, 1);
		chk(sub_cnt_o, 28'h000_0000);
		chk(week_cnt_o, 28'h000_0006);
		chk(wake_event_o, 0);
		// supply now present; week preloaded so next second carries into bit 3
		supply_present_pin_i = 1'b1;
		wr(0, 28'h000_0007);
		wr(2, 28'h000_0001);
		{sub_tick_sel_i, sub_repeat_i} = {3'h4, 1'b1};
		// the two writes used four cycles of this second
		n = 4;
		do begin
			@(negedge sys_clk_i);
			n++;
		end while (one_second_irq_o !== 1'b1 && n < 40000);
		chk(n, 32768);
		chk(week_cnt_o, 28'h000_0008);
		chk(sub_week_alarm_irq_o, 1);
		chk(sub_cnt_o, 28'h000_0001);
		chk(wake_event_o, 1);
		// one-shot countdown of three on the full-rate fractional tick
		sub_repeat_i = 1'b0;
		wr(2, 28'h000_0003);
		sub_tick_sel_i = 3'h1;
		n = 0;
		repeat (4) begin
			@(negedge sys_clk_i);
			if (sub_week_alarm_irq_o === 1'b1)
				n++;
		end
		chk(n, 1);
		chk(sub_cnt_o, 28'h000_0000);
		finish_test();
	end
endmodule // tb_top
